/* design/dsft_dev.sv */
`timescale 1ns/1ps
module dsft_dev (
  input  wire logic                                    clk,         // Device core clock
  input  wire logic                                    resetn,      // Reset, active low
  dsft_link_if.dev                                     link,        // Serial link
  output logic [dsft_pkg::N_CH*dsft_pkg::CODE_W-1:0]   dac_code,    // Output codes, channel 0 low
  output logic                                         dac_update   // Pulse on any output change
);
  import dsft_pkg::*;

  // Serial clock domain, frame-scoped state
  logic [5:0]       fcnt_q, fcnt_d;
  logic [31:0]      sr_q, sr_d;
  logic             fseen_q;
  // Serial clock domain, persistent state
  logic             pec_q, pec_d;
  logic             arm_q, arm_d;
  logic [1:0]       rch_q, rch_d;
  logic [15:0]      shd_q [N_CH];
  logic [15:0]      shd_d [N_CH];
  dsft_word_t       word_q, word_d;
  logic             tgl_q, tgl_d;
  logic             done;
  dsft_word_t       w;
  // Serial clock domain, output side
  logic [5:0]       rise_q, rise_d;
  logic             ffirst_q, ffirst_d;
  logic             so_q, so_d;
  logic [5:0]       dc;
  logic [5:0]       pos;
  logic [5:0]       idx;
  logic [23:0]      rb;

  // Bit counter and input shifter, cleared while frame is high
  always_comb begin
    fcnt_d = (fcnt_q == 6'h3F) ? fcnt_q : fcnt_q + 6'h01;
    sr_d   = {sr_q[30:0], link.serial_in};
  end

  always_ff @(negedge link.sclk or posedge link.frame_n) begin
    if (link.frame_n) begin
      fcnt_q  <= 6'h00;
      sr_q    <= 32'h0000_0000;
      fseen_q <= 1'b0;
    end else begin
      fcnt_q  <= fcnt_d;
      sr_q    <= sr_d;
      fseen_q <= 1'b1;
    end
  end

  // Word capture on the last falling edge of the frame
  always_comb begin
    done   = (fcnt_q != fcnt_d) && (fcnt_d == (pec_q ? FRAME_LEN_PEC : FRAME_LEN));
    w      = pec_q ? sr_d[31:8] : sr_d[23:0];
    pec_d  = pec_q;
    arm_d  = arm_q;
    rch_d  = rch_q;
    shd_d  = shd_q;
    word_d = word_q;
    tgl_d  = tgl_q;
    if (done) begin
      word_d = w;
      tgl_d  = ~tgl_q;
      arm_d  = dsft_is_read(w);
      if (dsft_is_read(w)) rch_d = w[W_CH +: 2];
      if (dsft_is_cfg(w)) pec_d = w[CFG_PEC];
      if (dsft_is_dac(w)) shd_d[w[W_CH +: 2]] = w[15:0];
    end
  end

  // Persistent state survives idle clock, reset without it
  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      pec_q  <= 1'b0;
      arm_q  <= 1'b0;
      rch_q  <= 2'h0;
      shd_q  <= '{default: 16'h0000};
      word_q <= 24'h00_0000;
      tgl_q  <= 1'b0;
    end else begin
      pec_q  <= pec_d;
      arm_q  <= arm_d;
      rch_q  <= rch_d;
      shd_q  <= shd_d;
      word_q <= word_d;
      tgl_q  <= tgl_d;
    end
  end

  // Readback bit select; first edge falling gives one don't-care bit less
  always_comb begin
    rise_d   = (rise_q == 6'h3F) ? rise_q : rise_q + 6'h01;
    ffirst_d = (rise_q == 6'h00) ? fseen_q : ffirst_q;
    dc       = ffirst_d ? DC_FALL : DC_RISE;
    rb       = {shd_q[rch_q], dsft_crc8({8'h00, shd_q[rch_q]})};
    pos      = rise_d - dc;
    idx      = 6'h17 - pos;
    so_d     = 1'b0;
    if (arm_q && (rise_d >= dc) && (pos < 6'h18)) so_d = rb[idx[4:0]];
  end

  // Serial out changes on rising edges within a frame, and clears when frame goes high
  always_ff @(posedge link.sclk or posedge link.frame_n) begin
    if (link.frame_n) begin
      rise_q   <= 6'h00;
      ffirst_q <= 1'b0;
      so_q     <= 1'b0;
    end else begin
      rise_q   <= rise_d;
      ffirst_q <= ffirst_d;
      so_q     <= so_d;
    end
  end

  assign link.serial_out    = so_q;
  assign link.serial_out_oe = ~link.frame_n;

  // Core clock domain: synchronisers and output registers
  logic [1:0]       fr_s_q, fr_s_d;
  logic [2:0]       ld_s_q, ld_s_d;
  logic [2:0]       tg_s_q, tg_s_d;
  logic             pend_q, pend_d;
  dsft_word_t       pw_q, pw_d;
  logic [15:0]      in_q  [N_CH];
  logic [15:0]      in_d  [N_CH];
  logic [15:0]      out_q [N_CH];
  logic [15:0]      out_d [N_CH];
  logic             upd_q, upd_d;
  logic             ld_fall;
  logic             tg_edge;

  // Word changes with its toggle and stays stable long after the toggle is seen, so it crosses as a quasi-static bus
  always_comb begin
    fr_s_d  = {fr_s_q[0], link.frame_n};
    ld_s_d  = {ld_s_q[1:0], link.load_strobe_n};
    tg_s_d  = {tg_s_q[1:0], tgl_q};
    ld_fall = ld_s_q[2] & ~ld_s_q[1];
    tg_edge = tg_s_q[2] ^ tg_s_q[1];
    pend_d  = pend_q;
    pw_d    = pw_q;
    in_d    = in_q;
    out_d   = out_q;
    upd_d   = 1'b0;
    if (pend_q && fr_s_q[1]) begin
      pend_d                 = 1'b0;
      in_d[pw_q[W_CH +: 2]]  = pw_q[15:0];
      if (!ld_s_q[1]) begin
        out_d[pw_q[W_CH +: 2]] = pw_q[15:0];
        upd_d                  = 1'b1;
      end
    end
    if (tg_edge && dsft_is_dac(word_q)) begin
      pend_d = 1'b1;
      pw_d   = word_q;
    end
    if (ld_fall) begin
      out_d = in_d;
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fr_s_q <= 2'h3;
      ld_s_q <= 3'h7;
      tg_s_q <= 3'h0;
      pend_q <= 1'b0;
      pw_q   <= 24'h00_0000;
      in_q   <= '{default: 16'h0000};
      out_q  <= '{default: 16'h0000};
      upd_q  <= 1'b0;
    end else begin
      fr_s_q <= fr_s_d;
      ld_s_q <= ld_s_d;
      tg_s_q <= tg_s_d;
      pend_q <= pend_d;
      pw_q   <= pw_d;
      in_q   <= in_d;
      out_q  <= out_d;
      upd_q  <= upd_d;
    end
  end

  // Flatten output codes
  for (genvar g = 0; g < N_CH; g++) begin : g_code
    assign dac_code[g*CODE_W +: CODE_W] = out_q[g];
  end

  assign dac_update = upd_q;

endmodule : dsft_dev

/* design/dsft_host.sv */
`timescale 1ns/1ps
// Function
// - Frame low; device samples on falling edges
// - Load low: update at frame rise
// - Frame carries exactly 24 or 32 bits
// - After configuration write, frame high 198 ns
// - After code write, frame high 5 us
// - Single update gap 20 us slew, else 5
// - Frame rise to load fall 20/5 us
// - Outputs respond within 500 ns of load
// - Serial out valid 40 ns after rise
// - Readback: 7 or 8 don't-care, 16 data
// - Check enabled: 8 check bits follow data
// - Serial clock idle while frame is high
module dsft_host (
  input  wire logic                clk,         // Host clock
  input  wire logic                resetn,      // Reset, active low
  dsft_link_if.host                link,        // Serial link
  input  wire logic                cmd_valid,   // Command word offered
  output logic                     cmd_ready,   // Command word taken
  input  wire dsft_pkg::dsft_word_t cmd_word,   // Command word
  input  wire logic                load_mode,   // 1: strobe held high, pulsed on request
  input  wire logic                load_req,    // Request one load pulse
  output logic                     load_busy,   // Load request still pending
  output logic                     rd_valid,    // Readback word ready, one cycle
  output logic [15:0]              rd_data,     // Readback data
  output logic [7:0]               rd_check,    // Readback check byte
  output logic                     packet_check,// Check mode in force
  output logic                     busy         // Frame or load pulse in progress
);
  import dsft_pkg::*;

  // One-hot sequencer states
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_SETUP = 6'h02,
    S_LOW   = 6'h04,
    S_HIGH  = 6'h08,
    S_TAIL  = 6'h10,
    S_LOAD  = 6'h20
  } dsft_state_e;

  dsft_state_e st_q, st_d;
  dsft_cyc_t   tmr_q, tmr_d;
  dsft_cyc_t   gap_q, gap_d;
  dsft_cyc_t   gneed_q, gneed_d;
  dsft_cyc_t   lneed_q, lneed_d;
  logic [5:0]  bits_q, bits_d;
  logic [5:0]  len_q, len_d;
  logic [31:0] tx_q, tx_d;
  logic [31:0] rx_q, rx_d;
  logic [1:0]  smp_q, smp_d;
  logic [1:0]  so_s_q, so_s_d;
  logic        frame_n_q, frame_n_d;
  logic        sclk_q, sclk_d;
  logic        sdi_q, sdi_d;
  logic        ldn_q, ldn_d;
  logic        lpend_q, lpend_d;
  logic        pec_q, pec_d;
  logic [3:0]  slew_q, slew_d;
  logic        rarm_q, rarm_d;
  logic        rnop_q, rnop_d;
  logic        rdv_q, rdv_d;
  logic [15:0] rdd_q, rdd_d;
  logic [7:0]  rdc_q, rdc_d;
  logic        load_go;
  logic        cmd_go;
  logic [31:0] rx_al;

  // Start conditions; a pending load whose gap is met is served before the next frame
  always_comb begin
    load_go   = (st_q == S_IDLE) && load_mode && lpend_q && (gap_q >= lneed_q);
    cmd_ready = (st_q == S_IDLE) && !load_go && (gap_q >= gneed_q);
    cmd_go    = cmd_ready && cmd_valid;
  end

  // Sequencer next state
  always_comb begin
    st_d      = st_q;
    tmr_d     = (tmr_q != 13'h0000) ? tmr_q - 13'h0001 : tmr_q;
    gap_d     = (gap_q == RST_GAP) ? gap_q : gap_q + 13'h0001;
    gneed_d   = gneed_q;
    lneed_d   = lneed_q;
    bits_d    = bits_q;
    len_d     = len_q;
    tx_d      = tx_q;
    rx_d      = rx_q;
    smp_d     = {smp_q[0], 1'b0};
    so_s_d    = {so_s_q[0], link.serial_out_line};
    frame_n_d = frame_n_q;
    sclk_d    = sclk_q;
    sdi_d     = sdi_q;
    ldn_d     = ldn_q;
    lpend_d   = lpend_q;
    pec_d     = pec_q;
    slew_d    = slew_q;
    rarm_d    = rarm_q;
    rnop_d    = rnop_q;
    rdv_d     = 1'b0;
    rdd_d     = rdd_q;
    rdc_d     = rdc_q;
    rx_al     = rx_q >> (len_q - 6'h17);
    // Sample serial out two cycles after each fall, past its settle time
    if (smp_q[1]) rx_d = {rx_q[30:0], so_s_q[1]};
    case (st_q)
      S_IDLE: begin
        ldn_d = load_mode;
        if (load_go) begin
          ldn_d   = 1'b0;
          lpend_d = 1'b0;
          tmr_d   = CYC_LOAD_LOW - 13'h0001;
          st_d    = S_LOAD;
        end else if (cmd_go) begin
          frame_n_d = 1'b0;
          sclk_d    = 1'b1;
          tx_d      = {cmd_word, pec_q ? dsft_crc8(cmd_word) : 8'h00};
          sdi_d     = cmd_word[23];
          len_d     = pec_q ? FRAME_LEN_PEC : FRAME_LEN;
          bits_d    = 6'h00;
          rx_d      = 32'h0000_0000;
          rnop_d    = rarm_q;
          rarm_d    = dsft_is_read(cmd_word);
          tmr_d     = CYC_SETUP - 13'h0001;
          st_d      = S_SETUP;
          gneed_d   = CYC_GAP_CFG;
          if (dsft_is_cfg(cmd_word)) begin
            pec_d  = cmd_word[CFG_PEC];
            slew_d = cmd_word[CFG_SLEW +: 4];
          end
          if (dsft_is_dac(cmd_word)) begin
            gneed_d = slew_q[cmd_word[W_CH +: 2]] ? CYC_GAP_SLEW : CYC_GAP_DAC;
            lneed_d = slew_q[cmd_word[W_CH +: 2]] ? CYC_GAP_SLEW : CYC_GAP_DAC;
          end
        end
      end
      S_SETUP: begin
        if (tmr_q == 13'h0000) begin
          sclk_d   = 1'b0;
          bits_d   = bits_q + 6'h01;
          smp_d[0] = 1'b1;
          tmr_d    = CYC_HALF - 13'h0001;
          st_d     = S_LOW;
        end
      end
      S_LOW: begin
        if (tmr_q == 13'h0000) begin
          sclk_d = 1'b1;
          if (bits_q == len_q) begin
            tmr_d = CYC_TAIL - 13'h0001;
            st_d  = S_TAIL;
          end else begin
            // Data moves at the rise, half a period before the sampling fall
            tx_d  = {tx_q[30:0], 1'b0};
            sdi_d = tx_q[30];
            tmr_d = CYC_HALF - 13'h0001;
            st_d  = S_HIGH;
          end
        end
      end
      S_HIGH: begin
        if (tmr_q == 13'h0000) begin
          sclk_d   = 1'b0;
          bits_d   = bits_q + 6'h01;
          smp_d[0] = 1'b1;
          tmr_d    = CYC_HALF - 13'h0001;
          st_d     = S_LOW;
        end
      end
      S_TAIL: begin
        if (tmr_q == 13'h0000) begin
          frame_n_d = 1'b1;
          gap_d     = 13'h0000;
          st_d      = S_IDLE;
          // Readback: 7 don't-care bits, then data, then check byte
          if (rnop_q) begin
            rdv_d = 1'b1;
            rdd_d = rx_al[15:0];
            rdc_d = (len_q == FRAME_LEN_PEC) ? rx_q[8:1] : 8'h00;
          end
        end
      end
      S_LOAD: begin
        ldn_d = 1'b0;
        if (tmr_q == 13'h0000) begin
          ldn_d = 1'b1;
          st_d  = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
    // A request in the cycle of its own clear is kept
    if (!load_mode) lpend_d = 1'b0;
    else if (load_req) lpend_d = 1'b1;
  end

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q      <= S_IDLE;
      tmr_q     <= 13'h0000;
      gap_q     <= RST_GAP;
      gneed_q   <= 13'h0000;
      lneed_q   <= 13'h0000;
      bits_q    <= 6'h00;
      len_q     <= FRAME_LEN;
      tx_q      <= 32'h0000_0000;
      rx_q      <= 32'h0000_0000;
      smp_q     <= 2'h0;
      so_s_q    <= 2'h0;
      frame_n_q <= 1'b1;
      sclk_q    <= 1'b1;
      sdi_q     <= 1'b0;
      ldn_q     <= 1'b1;
      lpend_q   <= 1'b0;
      pec_q     <= 1'b0;
      slew_q    <= 4'h0;
      rarm_q    <= 1'b0;
      rnop_q    <= 1'b0;
      rdv_q     <= 1'b0;
      rdd_q     <= 16'h0000;
      rdc_q     <= 8'h00;
    end else begin
      st_q      <= st_d;
      tmr_q     <= tmr_d;
      gap_q     <= gap_d;
      gneed_q   <= gneed_d;
      lneed_q   <= lneed_d;
      bits_q    <= bits_d;
      len_q     <= len_d;
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      smp_q     <= smp_d;
      so_s_q    <= so_s_d;
      frame_n_q <= frame_n_d;
      sclk_q    <= sclk_d;
      sdi_q     <= sdi_d;
      ldn_q     <= ldn_d;
      lpend_q   <= lpend_d;
      pec_q     <= pec_d;
      slew_q    <= slew_d;
      rarm_q    <= rarm_d;
      rnop_q    <= rnop_d;
      rdv_q     <= rdv_d;
      rdd_q     <= rdd_d;
      rdc_q     <= rdc_d;
    end
  end

  // Link pins come straight from flops; no glitches on the clock
  assign link.frame_n       = frame_n_q;
  assign link.sclk          = sclk_q;
  assign link.serial_in     = sdi_q;
  assign link.load_strobe_n = ldn_q;

  // User side
  assign rd_valid     = rdv_q;
  assign rd_data      = rdd_q;
  assign rd_check     = rdc_q;
  assign packet_check = pec_q;
  assign load_busy    = lpend_q;
  assign busy         = (st_q != S_IDLE);

endmodule : dsft_host

/* design/dsft_link_if.sv */
`timescale 1ns/1ps
interface dsft_link_if;
  logic frame_n;          // Frame select, low during a frame
  logic sclk;             // Serial clock from the host
  logic serial_in;        // Host to device data
  logic load_strobe_n;    // Load strobe, active low
  logic serial_out;       // Device data drive
  logic serial_out_oe;    // Device drives serial out
  logic serial_out_line;  // Resolved wire, low when released

  // Released line reads low
  assign serial_out_line = serial_out & serial_out_oe;

  modport host (output frame_n, output sclk, output serial_in, output load_strobe_n, input serial_out_line);
  modport dev  (input frame_n, input sclk, input serial_in, input load_strobe_n,
                output serial_out, output serial_out_oe);
endinterface : dsft_link_if

/* design/dsft_pkg.sv */
package dsft_pkg;

  // Clock rate of the user-side clock
  localparam int CLK_MHZ = 200;

  // Link timing, as printed, in ns or us
  localparam int T_SCLK_HALF_NS = 50;   // 100 ns serial clock, well above the 33 ns minimum
  localparam int T_SETUP_NS     = 13;   // Frame fall to first clock fall
  localparam int T_TAIL_NS      = 13;   // Last clock fall to frame rise
  localparam int T_GAP_CFG_NS   = 198;  // Frame high after a configuration write
  localparam int T_GAP_DAC_US   = 5;    // Frame high after a code write, slew off
  localparam int T_GAP_SLEW_US  = 20;   // Frame high after a code write, slew on
  localparam int T_LOAD_LOW_NS  = 10;   // Load strobe low width
  localparam int T_OUT_RESP_NS  = 500;  // Load fall to output change, longest
  localparam int T_SO_VALID_NS  = 40;   // Clock rise to serial out valid, longest

  // Cycle counts; least times round up
  typedef logic [12:0] dsft_cyc_t;
  localparam dsft_cyc_t CYC_HALF      = dsft_cyc_t'((T_SCLK_HALF_NS * CLK_MHZ + 999) / 1000);
  localparam dsft_cyc_t CYC_SETUP     = dsft_cyc_t'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam dsft_cyc_t CYC_TAIL      = dsft_cyc_t'((T_TAIL_NS * CLK_MHZ + 999) / 1000);
  localparam dsft_cyc_t CYC_GAP_CFG   = dsft_cyc_t'((T_GAP_CFG_NS * CLK_MHZ + 999) / 1000);
  localparam dsft_cyc_t CYC_GAP_DAC   = dsft_cyc_t'(T_GAP_DAC_US * CLK_MHZ);
  localparam dsft_cyc_t CYC_GAP_SLEW  = dsft_cyc_t'(T_GAP_SLEW_US * CLK_MHZ);
  localparam dsft_cyc_t CYC_LOAD_LOW  = dsft_cyc_t'((T_LOAD_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam dsft_cyc_t CYC_OUT_RESP  = dsft_cyc_t'((T_OUT_RESP_NS * CLK_MHZ) / 1000);
  localparam dsft_cyc_t RST_GAP       = 13'h1FFF;

  // Frame layout
  localparam logic [5:0] FRAME_LEN     = 6'h18;  // 24 bits
  localparam logic [5:0] FRAME_LEN_PEC = 6'h20;  // 32 bits with check byte
  localparam logic [5:0] DC_FALL       = 6'h07;  // Don't-care bits, first edge falling
  localparam logic [5:0] DC_RISE       = 6'h08;  // Don't-care bits, first edge rising
  localparam int         N_CH          = 4;
  localparam int         CODE_W        = 16;

  // Command word fields
  localparam int W_READ   = 23;
  localparam int W_CFG    = 22;
  localparam int W_DAC    = 21;
  localparam int W_CH     = 16;
  localparam int CFG_PEC  = 0;
  localparam int CFG_SLEW = 4;

  typedef logic [23:0] dsft_word_t;

  // Word kind decode, read outranks config outranks code write
  function automatic logic dsft_is_read(input dsft_word_t w);
    return w[W_READ];
  endfunction : dsft_is_read

  function automatic logic dsft_is_cfg(input dsft_word_t w);
    return !w[W_READ] && w[W_CFG];
  endfunction : dsft_is_cfg

  function automatic logic dsft_is_dac(input dsft_word_t w);
    return !w[W_READ] && !w[W_CFG] && w[W_DAC];
  endfunction : dsft_is_dac

  // CRC-8, polynomial x^8+x^2+x+1, MSB first
  function automatic logic [7:0] dsft_crc8(input dsft_word_t d);
    logic [7:0] c;
    logic       fb;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : dsft_crc8

endpackage : dsft_pkg

/* tb/dsft_link_asserts.sv */
`timescale 1ns/1ps
module dsft_link_asserts (
  input wire logic clk,           // Core clock
  input wire logic resetn,        // Reset, active low
  input wire logic frame_n,       // Frame select
  input wire logic sclk,          // Serial clock
  input wire logic serial_in,     // Host to device data
  input wire logic load_strobe_n, // Load strobe
  input wire logic serial_out,    // Device data drive
  input wire logic serial_out_oe, // Device drive enable
  input wire logic dac_update     // Device output pulse
);
  localparam int GAP_CFG = 40;    // 198 ns in whole cycles
  localparam int GAP_DAC = 1000;  // 5 us
  logic [5:0]  falls_q, falls_d;
  logic [2:0]  kind_q, kind_d;
  logic [12:0] gap_q, gap_d;
  logic        sclk_q, dac_q, dac_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Falls per frame, first three bits, high time since the last frame
  always_comb begin
    falls_d = frame_n ? 6'h00 : falls_q + {5'h00, sclk_q & ~sclk};
    kind_d  = (!frame_n && sclk_q && !sclk && falls_q < 6'h03) ? {kind_q[1:0], serial_in} : kind_q;
    dac_d   = dac_q;
    if (frame_n && falls_q != 6'h00) begin
      kind_d = 3'h0;
      dac_d  = (kind_q == 3'h1);
    end
    gap_d = frame_n ? ((gap_q == 13'h1FFF) ? gap_q : gap_q + 13'h0001) : 13'h0000;
  end

  // Saturated gap at reset so the first frame is never flagged
  always_ff @(posedge clk) begin
    if (!resetn) begin
      falls_q <= 6'h00;
      kind_q  <= 3'h0;
      gap_q   <= 13'h1FFF;
      sclk_q  <= 1'b1;
      dac_q   <= 1'b0;
    end else begin
      falls_q <= falls_d;
      kind_q  <= kind_d;
      gap_q   <= gap_d;
      sclk_q  <= sclk;
      dac_q   <= dac_d;
    end
  end

  a_frame_len: assert property ($rose(frame_n) |-> falls_q == 6'h18 || falls_q == 6'h20)
    else $error("frame bit count wrong");
  a_sclk_idle: assert property (frame_n |-> sclk)
    else $error("serial clock moved between frames");
  a_setup_fall: assert property ($fell(frame_n) |-> sclk [*3])
    else $error("clock fell too soon after frame start");
  a_tail_hold: assert property ($fell(sclk) |-> !frame_n [*3])
    else $error("frame ended too soon after clock fall");
  a_data_stable: assert property ($fell(sclk) |-> $stable(serial_in) ##1 $stable(serial_in))
    else $error("serial in moved at sampling edge");
  // Gap counter holds the whole high time in cycles when the next edge is seen
  a_gap_rule: assert property ($fell(frame_n) |-> gap_q >= (dac_q ? GAP_DAC : GAP_CFG))
    else $error("frame gap too short");
  a_load_gap: assert property ($fell(load_strobe_n) |-> frame_n && gap_q >= (dac_q ? GAP_DAC : 1))
    else $error("load strobe too soon after frame");
  a_out_drive: assert property ($fell(frame_n) |-> serial_out_oe && !serial_out)
    else $error("serial out not driven low at frame start");
  a_out_resp: assert property ($fell(load_strobe_n) |-> ##[1:100] dac_update)
    else $error("no output update after load");
  a_so_edge: assert property ($changed(serial_out) && !frame_n |-> $rose(sclk))
    else $error("serial out changed away from clock rise");
endmodule : dsft_link_asserts

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import dsft_pkg::*;
  logic                   clk, resetn, cmd_valid, load_mode, load_req;
  logic                   cmd_ready, load_busy, rd_valid, packet_check, busy, dac_update;
  dsft_word_t             cmd_word;
  logic [15:0]            rd_data;
  logic [7:0]             rd_check;
  logic [N_CH*CODE_W-1:0] dac_code;
  int                     error_cnt = 0, check_count = 0, hi_cnt = 0, gap_seen = 0, rd_seen = 0;

  dsft_link_if lnk ();
  dsft_host u_dsft_host (.clk(clk), .resetn(resetn), .link(lnk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_word(cmd_word), .load_mode(load_mode), .load_req(load_req), .load_busy(load_busy), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_check(rd_check), .packet_check(packet_check), .busy(busy));
  dsft_dev u_dsft_dev (.clk(clk), .resetn(resetn), .link(lnk), .dac_code(dac_code), .dac_update(dac_update));
  dsft_link_asserts u_dsft_link_asserts (.clk(clk), .resetn(resetn), .frame_n(lnk.frame_n), .sclk(lnk.sclk),
    .serial_in(lnk.serial_in), .load_strobe_n(lnk.load_strobe_n), .serial_out(lnk.serial_out),
    .serial_out_oe(lnk.serial_out_oe), .dac_update(dac_update));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Frame gap and readback pulses, sampled away from the active edge
  always @(negedge clk) begin
    if (lnk.frame_n === 1'b1) hi_cnt++;
    else begin
      if (hi_cnt != 0) gap_seen = hi_cnt;
      hi_cnt = 0;
    end
    if (rd_valid === 1'b1) rd_seen++;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic tmo(input string what);
    error_cnt++;
    $display("[ERR] %s exp done got timeout", what);
    wrap_up();
  endtask : tmo

  function automatic logic [7:0] crc_ref(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc_ref

  // Offer a word, hold it until taken, then wait out the frame
  task automatic send(input dsft_word_t w);
    int n;
    cmd_word  = w;
    cmd_valid = 1'b1;
    for (n = 0; n < 6000 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (cmd_ready !== 1'b1) tmo("cmd_ready");
    @(negedge clk);
    cmd_valid = 1'b0;
    // A 32-bit frame keeps busy high for about 640 cycles
    for (n = 0; n < 1000 && busy !== 1'b0; n++) @(negedge clk);
    if (busy !== 1'b0) tmo("busy");
    // One more edge so the pulse monitor has counted the frame's end
    @(negedge clk);
  endtask : send

  task automatic expect_code(input int ch, input logic [15:0] ex);
    int n;
    for (n = 0; n < 200 && dac_code[ch*16 +: 16] !== ex; n++) @(negedge clk);
    `CHK("dac_code", ex, dac_code[ch*16 +: 16])
  endtask : expect_code

  // Strobe held high: input register only, outputs on strobe fall
  task automatic t_strobe_mode();
    int n;
    send(24'h201234);
    repeat (150) @(negedge clk);
    `CHK("held code", 16'h0000, dac_code[15:0])
    load_req = 1'b1;
    @(negedge clk);
    load_req = 1'b0;
    `CHK("load_busy", 1'b1, load_busy)
    for (n = 0; n < 1500 && load_busy !== 1'b0; n++) @(negedge clk);
    if (load_busy !== 1'b0) tmo("load_busy");
    expect_code(0, 16'h1234);
    send(24'h21A5C3);
    for (n = 0; n < 1500 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (cmd_ready !== 1'b1) tmo("cmd_ready");
    load_mode = 1'b0;
    expect_code(1, 16'hA5C3);
  endtask : t_strobe_mode

  // Strobe tied low: back to back code writes
  task automatic t_tied_low();
    send(24'h238001);
    expect_code(3, 16'h8001);
    send(24'h220001);
    `CHK("code gap", 1'b1, gap_seen >= 1000)
    expect_code(2, 16'h0001);
  endtask : t_tied_low

  task automatic t_readback();
    send(24'h400000);
    send(24'h810000);
    `CHK("config gap", 1'b1, gap_seen >= 40)
    rd_seen = 0;
    send(24'h000000);
    `CHK("rd count", 1, rd_seen)
    `CHK("rd_data", 16'hA5C3, rd_data)
    `CHK("rd_check", 8'h00, rd_check)
  endtask : t_readback

  // Check mode: 32-bit frames with trailing check byte
  task automatic t_check_mode();
    send(24'h400001);
    `CHK("check on", 1'b1, packet_check)
    send(24'h830000);
    send(24'h000000);
    `CHK("rd_data", 16'h8001, rd_data)
    `CHK("rd_check", crc_ref({8'h00, 16'h8001}), rd_check)
    send(24'h400000);
    `CHK("check off", 1'b0, packet_check)
  endtask : t_check_mode

  task automatic t_slew();
    send(24'h400020);
    send(24'h214321);
    send(24'h000000);
    `CHK("slew gap", 1'b1, gap_seen >= 4000)
    expect_code(1, 16'h4321);
  endtask : t_slew

  initial begin
    resetn    = 1'b0;
    cmd_valid = 1'b0;
    cmd_word  = 24'h000000;
    load_mode = 1'b1;
    load_req  = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_strobe_mode();
    t_tied_low();
    t_readback();
    t_check_mode();
    t_slew();
    wrap_up();
  end
endmodule : tb_top
